// file: hw/i2cs_defs.svh
// constants of the two-wire slave port: offsets, bit positions, reset values
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`ifndef I2CS_DEFS_SVH
`define I2CS_DEFS_SVH

// register byte offsets
`define I2CS_OFS_DATA 8'h00
`define I2CS_OFS_STAT 8'h04
`define I2CS_OFS_CTL 8'h08
`define I2CS_OFS_CTL2 8'h0c
`define I2CS_OFS_OWN 8'h10
`define I2CS_OFS_IRQ 8'h14

// status bit positions
`define I2CS_ST_BF 0
`define I2CS_ST_UA 1
`define I2CS_ST_RW 2
`define I2CS_ST_S 3
`define I2CS_ST_P 4
`define I2CS_ST_DA 5

// control and interrupt bit positions
`define I2CS_CTL_TEN 3
`define I2CS_CTL_CKP 4
`define I2CS_CTL_EN 5
`define I2CS_CTL_OV 6
`define I2CS_CTL2_SEN 0
`define I2CS_CTL2_BUSY 7
`define I2CS_IRQ_BIT 3

// reset values and fixed codes
`define I2CS_CKP_RST 1'b1
`define I2CS_TEN_HI 5'h1e
`define I2CS_LAST_BIT 4'h7
`define I2CS_ACK_BIT 4'h8
`define I2CS_START_CNT 4'hf

`endif

// file: hw/i2cs_pkg.sv
// types of the two-wire slave port
package i2cs_pkg;

    typedef enum logic [2:0] {
        P_IDLE,
        P_ADDR,
        P_ADDR2,
        P_RX,
        P_TX
    } i2cs_phase_t;

    typedef struct packed {
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        i2cs_phase_t phase;
        logic [3:0] bitcnt;
        logic [7:0] sr;
        logic [7:0] data_buffer;
        logic [7:0] own_address_reg;
        logic buffer_full_flag;
        logic receive_overflow_flag;
        logic address_update_flag;
        logic rw;
        logic da;
        logic st;
        logic sp;
        logic clock_release_bit;
        logic stretch_enable;
        logic ten_bit;
        logic en;
        logic port_irq_flag;
        logic ua_hold;
        logic ack_drv;
        logic hi_seen;
        logic [3:0] ctl2_hi;
        logic scl_oe;
        logic sda_oe;
        logic pin_lvl;
        logic wb_ack;
        logic [31:0] wb_dat;
    } i2cs_state_t;

endpackage

// file: hw/i2cs_top.sv
// two-wire slave port with clock stretching behind a wishbone slave
`timescale 1ns/100ps
`default_nettype none
`include "i2cs_defs.svh"

module i2cs_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o
);
    import i2cs_pkg::*;

    i2cs_state_t r;
    i2cs_state_t n;

    // ------------------------------------------------------------------
    // line events
    // ------------------------------------------------------------------
    // only the second and third sync stages are looked at
    logic scl_rise_w;
    logic scl_fall_w;
    logic start_w;
    logic stop_w;
    logic bus_w;
    logic fall9_w;
    logic wb_req_w;
    logic [7:0] byte_w;
    logic match7_w;
    logic match10_w;
    logic ovf_w;

    assign scl_rise_w = r.scl_s[1] & ~r.scl_s[2];
    assign scl_fall_w = ~r.scl_s[1] & r.scl_s[2];
    assign start_w = r.scl_s[1] & r.scl_s[2] & ~r.sda_s[1] & r.sda_s[2];
    assign stop_w = r.scl_s[1] & r.scl_s[2] & r.sda_s[1] & ~r.sda_s[2];
    assign bus_w = r.en & ~start_w & ~stop_w & (r.phase != P_IDLE);
    assign fall9_w = bus_w & scl_fall_w & (r.bitcnt == `I2CS_ACK_BIT);
    assign wb_req_w = wb_cyc_i & wb_stb_i & ~r.wb_ack;
    assign byte_w = r.sr;
    assign match7_w = byte_w[7:1] == r.own_address_reg[7:1];
    assign match10_w = (byte_w[7:3] == `I2CS_TEN_HI)
        && (byte_w[2:1] == r.own_address_reg[2:1]);
    assign ovf_w = r.buffer_full_flag | r.receive_overflow_flag;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        n = r;
        n.scl_s = {r.scl_s[1:0], scl_i};
        n.sda_s = {r.sda_s[1:0], sda_i};
        n.wb_ack = 1'b0;

        // bus slave first, so hardware events below win over it
        if (wb_req_w) begin
            n.wb_ack = 1'b1;
            n.wb_dat = 32'h0;
            if (wb_we_i && wb_sel_i[0]) begin
                if (wb_adr_i == `I2CS_OFS_DATA) begin
                    n.data_buffer = wb_dat_i[7:0];
                    if (r.rw) begin
                        n.sr = wb_dat_i[7:0];
                        n.buffer_full_flag = 1'b1;
                    end
                end else if (wb_adr_i == `I2CS_OFS_CTL) begin
                    // overflow can only be cleared by software
                    n.receive_overflow_flag = r.receive_overflow_flag
                        & wb_dat_i[`I2CS_CTL_OV];
                    n.en = wb_dat_i[`I2CS_CTL_EN];
                    n.clock_release_bit = wb_dat_i[`I2CS_CTL_CKP];
                    n.ten_bit = wb_dat_i[`I2CS_CTL_TEN];
                end else if (wb_adr_i == `I2CS_OFS_CTL2) begin
                    n.stretch_enable = wb_dat_i[`I2CS_CTL2_SEN];
                    n.ctl2_hi = wb_dat_i[4:1];
                end else if (wb_adr_i == `I2CS_OFS_OWN) begin
                    n.own_address_reg = wb_dat_i[7:0];
                    n.address_update_flag = 1'b0;
                    n.ua_hold = 1'b0;
                end else if (wb_adr_i == `I2CS_OFS_IRQ) begin
                    n.port_irq_flag = r.port_irq_flag
                        & wb_dat_i[`I2CS_IRQ_BIT];
                end
            end else if (!wb_we_i) begin
                if (wb_adr_i == `I2CS_OFS_DATA) begin
                    n.wb_dat[7:0] = r.data_buffer;
                    if (!r.rw) begin
                        n.buffer_full_flag = 1'b0;
                    end
                end else if (wb_adr_i == `I2CS_OFS_STAT) begin
                    n.wb_dat[`I2CS_ST_BF] = r.buffer_full_flag;
                    n.wb_dat[`I2CS_ST_UA] = r.address_update_flag;
                    n.wb_dat[`I2CS_ST_RW] = r.rw;
                    n.wb_dat[`I2CS_ST_S] = r.st;
                    n.wb_dat[`I2CS_ST_P] = r.sp;
                    n.wb_dat[`I2CS_ST_DA] = r.da;
                end else if (wb_adr_i == `I2CS_OFS_CTL) begin
                    n.wb_dat[`I2CS_CTL_OV] = r.receive_overflow_flag;
                    n.wb_dat[`I2CS_CTL_EN] = r.en;
                    n.wb_dat[`I2CS_CTL_CKP] = r.clock_release_bit;
                    n.wb_dat[`I2CS_CTL_TEN] = r.ten_bit;
                end else if (wb_adr_i == `I2CS_OFS_CTL2) begin
                    n.wb_dat[`I2CS_CTL2_SEN] = r.stretch_enable;
                    n.wb_dat[4:1] = r.ctl2_hi;
                    n.wb_dat[`I2CS_CTL2_BUSY] = r.rw | r.stretch_enable
                        | (|r.ctl2_hi);
                end else if (wb_adr_i == `I2CS_OFS_OWN) begin
                    n.wb_dat[7:0] = r.own_address_reg;
                end else if (wb_adr_i == `I2CS_OFS_IRQ) begin
                    n.wb_dat[`I2CS_IRQ_BIT] = r.port_irq_flag;
                end
            end
        end

        // ------------------------------------------------------------------
        // serial engine
        // ------------------------------------------------------------------
        if (!r.en) begin
            n.phase = P_IDLE;
            n.ack_drv = 1'b0;
            n.ua_hold = 1'b0;
        end else if (start_w) begin
            n.st = 1'b1;
            n.sp = 1'b0;
            n.phase = P_ADDR;
            // the start's own clock fall wraps this to zero, so the
            // byte ends on the eighth data fall and not the seventh
            n.bitcnt = `I2CS_START_CNT;
            n.ack_drv = 1'b0;
        end else if (stop_w) begin
            n.sp = 1'b1;
            n.st = 1'b0;
            n.phase = P_IDLE;
            n.ack_drv = 1'b0;
            n.ua_hold = 1'b0;
            n.hi_seen = 1'b0;
        end else if (r.phase != P_IDLE) begin
            if (scl_rise_w) begin
                if (r.bitcnt < `I2CS_ACK_BIT) begin
                    if (r.phase != P_TX) begin
                        n.sr = {r.sr[6:0], r.sda_s[1]};
                    end
                end else if (r.phase == P_TX && r.sda_s[1]) begin
                    // master said no more: drop back and wait for a start
                    n.phase = P_IDLE;
                    n.buffer_full_flag = 1'b0;
                    n.address_update_flag = 1'b0;
                    n.rw = 1'b0;
                    n.da = 1'b0;
                end
            end
            if (scl_fall_w) begin
                if (r.bitcnt == `I2CS_LAST_BIT) begin
                    n.bitcnt = `I2CS_ACK_BIT;
                    case (r.phase)
                        P_ADDR: begin
                            n.da = 1'b0;
                            n.phase = P_IDLE;
                            if (byte_w[0] && (r.ten_bit ? (match10_w
                                && r.hi_seen) : match7_w)) begin
                                n.rw = 1'b1;
                                n.data_buffer = byte_w;
                                n.ack_drv = 1'b1;
                                n.phase = P_TX;
                            end else if (!byte_w[0] && (r.ten_bit
                                ? match10_w : match7_w)) begin
                                n.rw = 1'b0;
                                if (ovf_w) begin
                                    n.receive_overflow_flag = 1'b1;
                                end else begin
                                    n.data_buffer = byte_w;
                                    n.buffer_full_flag = 1'b1;
                                    n.ack_drv = 1'b1;
                                    n.phase = r.ten_bit ? P_ADDR2 : P_RX;
                                    n.address_update_flag = r.ten_bit;
                                    n.hi_seen = 1'b0;
                                end
                            end
                        end
                        P_ADDR2: begin
                            n.phase = P_IDLE;
                            if (byte_w == r.own_address_reg) begin
                                if (ovf_w) begin
                                    n.receive_overflow_flag = 1'b1;
                                end else begin
                                    n.data_buffer = byte_w;
                                    n.buffer_full_flag = 1'b1;
                                    n.ack_drv = 1'b1;
                                    n.address_update_flag = 1'b1;
                                    n.hi_seen = 1'b1;
                                    n.phase = P_RX;
                                end
                            end
                        end
                        P_RX: begin
                            n.da = 1'b1;
                            if (ovf_w) begin
                                n.receive_overflow_flag = 1'b1;
                            end else begin
                                n.data_buffer = byte_w;
                                n.buffer_full_flag = 1'b1;
                                n.ack_drv = 1'b1;
                            end
                        end
                        P_TX: begin
                            n.da = 1'b1;
                            n.buffer_full_flag = 1'b0;
                        end
                        default: begin
                            n.phase = P_IDLE;
                        end
                    endcase
                end else if (r.bitcnt == `I2CS_ACK_BIT) begin
                    n.bitcnt = 4'h0;
                    n.ack_drv = 1'b0;
                    n.port_irq_flag = 1'b1;
                    if (r.address_update_flag) begin
                        n.ua_hold = 1'b1;
                    end else if (r.phase == P_RX && r.da
                        && r.stretch_enable && r.buffer_full_flag) begin
                        n.clock_release_bit = 1'b0;
                    end else if (r.phase == P_TX && !r.buffer_full_flag) begin
                        n.clock_release_bit = 1'b0;
                    end
                end else begin
                    n.bitcnt = 4'(r.bitcnt + 4'h1);
                    if (r.phase == P_TX) begin
                        n.sr = {r.sr[6:0], 1'b0};
                    end
                end
            end
        end

        // pins change after line events or bus writes, so a data write in transmit can move sda mid clock-high
        n.pin_lvl = 1'b0;
        n.scl_oe = n.en & (~n.clock_release_bit | n.ua_hold);
        n.sda_oe = n.ack_drv | (n.phase == P_TX && n.bitcnt < `I2CS_ACK_BIT
            && n.buffer_full_flag && !n.sr[7]);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '0;
            r.clock_release_bit <= `I2CS_CKP_RST;
            r.scl_s <= 3'h7;
            r.sda_s <= 3'h7;
        end else begin
            r <= n;
        end
    end

    assign wb_dat_o = r.wb_dat;
    assign wb_ack_o = r.wb_ack;
    assign scl_o = r.pin_lvl;
    assign sda_o = r.pin_lvl;
    assign scl_oe_o = r.scl_oe;
    assign sda_oe_o = r.sda_oe;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_rx_full_ninth;
        fall9_w && r.phase == P_RX && r.da && r.stretch_enable
            && r.buffer_full_flag && !r.address_update_flag;
    endsequence

    sequence s_held_low;
        !r.clock_release_bit ##1 scl_oe_o;
    endsequence

    sequence s_tx_empty_ninth;
        fall9_w && r.phase == P_TX && !r.buffer_full_flag
            && !r.address_update_flag;
    endsequence

    a_rx_stretch_held: assert property (
        s_rx_full_ninth |=> s_held_low)
        else $error("receive stretch did not hold the clock");

    a_rx_no_stretch: assert property (
        fall9_w && r.phase == P_RX && !r.buffer_full_flag
            && r.clock_release_bit && !wb_stb_i
        |=> r.clock_release_bit)
        else $error("clock stretched with empty buffer");

    a_tx_stretch_held: assert property (
        s_tx_empty_ninth |=> s_held_low)
        else $error("transmit stretch missing");

    a_tx_no_stretch: assert property (
        fall9_w && r.phase == P_TX && r.buffer_full_flag
            && r.clock_release_bit && !r.address_update_flag && !wb_stb_i
        |=> r.clock_release_bit ##1 !scl_oe_o)
        else $error("transmit stretched with loaded buffer");

    a_nack_to_idle: assert property (
        bus_w && r.phase == P_TX && scl_rise_w
            && r.bitcnt == `I2CS_ACK_BIT && r.sda_s[1]
        |=> r.phase == P_IDLE && !r.rw && !r.buffer_full_flag)
        else $error("master nack did not end the transfer");

    a_irq_per_byte: assert property (
        fall9_w |=> r.port_irq_flag && r.bitcnt == 4'h0)
        else $error("interrupt flag not set on ninth fall");

    a_ovf_nack_given: assert property (
        bus_w && r.phase == P_RX && scl_fall_w
            && r.bitcnt == `I2CS_LAST_BIT && ovf_w
        |=> !r.ack_drv && r.receive_overflow_flag && !sda_oe_o)
        else $error("overflow byte was acknowledged");

    a_ack_drives_sda: assert property (
        r.ack_drv |-> sda_oe_o && !sda_o)
        else $error("acknowledge not driven low");

    a_ua_release: assert property (
        wb_req_w && wb_we_i && wb_sel_i[0] && wb_adr_i == `I2CS_OFS_OWN
            && !fall9_w
        |=> !r.address_update_flag ##1 (r.clock_release_bit
            -> !scl_oe_o))
        else $error("own address write did not release");

    a_ua_stretch: assert property (
        fall9_w && r.address_update_flag && r.clock_release_bit && !wb_req_w
        |=> r.ua_hold && r.clock_release_bit ##1 scl_oe_o)
        else $error("address phase not stretched");

    a_wb_ack_once: assert property (
        wb_req_w |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer not a single pulse");

    sequence s_read_addr_end;
        bus_w && scl_fall_w && r.phase == P_ADDR
            && r.bitcnt == `I2CS_LAST_BIT && byte_w[0] && !r.ten_bit
            && match7_w;
    endsequence

    a_read_addr_ack: assert property (
        s_read_addr_end |=> r.rw && r.ack_drv && sda_oe_o
            && r.phase == P_TX && r.data_buffer == $past(byte_w))
        else $error("read address not acknowledged");

    a_write_addr_ack: assert property (
        bus_w && scl_fall_w && r.phase == P_ADDR
            && r.bitcnt == `I2CS_LAST_BIT && !byte_w[0] && !r.ten_bit
            && match7_w && !ovf_w
        |=> !r.rw && r.buffer_full_flag && sda_oe_o
            && r.data_buffer == $past(byte_w))
        else $error("write address not acknowledged");

    a_ua_second_byte: assert property (
        bus_w && scl_fall_w && r.phase == P_ADDR2
            && r.bitcnt == `I2CS_LAST_BIT && byte_w == r.own_address_reg
            && !ovf_w
        |=> r.address_update_flag && sda_oe_o && r.phase == P_RX)
        else $error("second address byte did not ask for update");

    // a buffer write mid-byte is a collision and is left out here
    a_tx_bit_stable: assert property (
        bus_w && r.phase == P_TX && r.scl_s[1] && r.scl_s[2]
            && r.bitcnt < `I2CS_ACK_BIT && !wb_req_w
        |=> $stable(sda_oe_o))
        else $error("transmit bit changed while clock high");

endmodule

`default_nettype wire

// file: testbench/i2cs_master_model.sv
// two-wire bus master model facing the slave port
`timescale 1ns/100ps
`default_nettype none
module i2cs_master_model (
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_oe_o,
    output logic sda_oe_o,
    output logic ack_ph_o,
    output logic hang_o
);
    // --------
    // line phases
    // --------
    initial begin
        scl_oe_o = 1'b0;
        sda_oe_o = 1'b0;
        ack_ph_o = 1'b0;
        hang_o = 1'b0;
    end

    // a stretching slave holds scl low; give up after 4 us
    task automatic rise();
        int n;
        scl_oe_o = 1'b0;
        for (n = 0; n < 800 && scl_i !== 1'b1; n++) begin
            #5;
        end
        if (n >= 800) begin
            hang_o = 1'b1;
        end
        #31.25;
    endtask

    task automatic start();
        sda_oe_o = 1'b0;
        rise();
        #31.25;
        sda_oe_o = 1'b1;
        #31.25;
        scl_oe_o = 1'b1;
        #31.25;
    endtask

    task automatic stop();
        sda_oe_o = 1'b1;
        #31.25;
        rise();
        #31.25;
        sda_oe_o = 1'b0;
        #62.5;
    endtask

    // eight bits msb first, then the acknowledge bit
    task automatic xfer(input logic [7:0] tx, input logic ack_in,
                        output logic [7:0] rx, output logic ack_out);
        logic [8:0] v;
        logic [8:0] r;
        v = {tx, ack_in};
        for (int i = 8; i >= 0; i--) begin
            sda_oe_o = ~v[i];
            #31.25;
            rise();
            ack_ph_o = (i == 0);
            r[i] = sda_i;
            #31.25;
            scl_oe_o = 1'b1;
            ack_ph_o = 1'b0;
            #31.25;
        end
        #62.5;
        sda_oe_o = 1'b0;
        #62.5;
        rx = r[8:1];
        ack_out = r[0];
    endtask
endmodule
`default_nettype wire

// file: testbench/test_i2c_slave_xfer_clock_stretch.sv
// self-checking bench of the two-wire slave port
`timescale 1ns/100ps
`default_nettype none
`include "i2cs_defs.svh"
module test_i2c_slave_xfer_clock_stretch;
    import i2cs_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdat;
    logic ack_o;
    logic d_scl;
    logic d_scl_oe;
    logic d_sda;
    logic d_sda_oe;
    logic m_scl;
    logic m_sda;
    logic m_ack;
    logic m_hang;
    logic scl_w;
    logic sda_w;
    int miscompares = 0;
    int checks = 0;

    always #5 clk_i = ~clk_i;
    // open-drain lines with pull-ups
    assign scl_w = (d_scl_oe ? d_scl : 1'b1) & ~m_scl;
    assign sda_w = (d_sda_oe ? d_sda : 1'b1) & ~m_sda;

    i2cs_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
        .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack_o), .scl_i(scl_w),
        .scl_o(d_scl), .scl_oe_o(d_scl_oe), .sda_i(sda_w), .sda_o(d_sda),
        .sda_oe_o(d_sda_oe));
    i2cs_master_model m (.scl_i(scl_w), .sda_i(sda_w), .scl_oe_o(m_scl),
        .sda_oe_o(m_sda), .ack_ph_o(m_ack), .hang_o(m_hang));

    // --------
    // helpers
    // --------
    task automatic test_done();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic fail(input string s);
        miscompares++;
        $display("[ERR] %0t %s", $time, s);
    endtask
    task automatic chk8(input logic [7:0] g, e);
        checks++;
        if (g !== e) fail($sformatf("got %h want %h", g, e));
    endtask
    task automatic chk1(input logic g, e);
        checks++;
        if (g !== e) fail($sformatf("got %b want %b", g, e));
    endtask
    task automatic wb(input logic w, input logic [7:0] ad, dt,
                      output logic [7:0] q);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= ad;
        wd <= {24'h0, dt};
        for (n = 0; n < 50; n++) begin
            @(posedge clk_i);
            if (ack_o === 1'b1) break;
        end
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50) begin
            fail("no bus answer");
            test_done();
        end
    endtask
    task automatic wr(input logic [7:0] ad, dt);
        logic [7:0] q;
        wb(1'b1, ad, dt, q);
    endtask
    task automatic rc(input logic [7:0] ad, mk, e);
        logic [7:0] q;
        wb(1'b0, ad, 8'h00, q);
        chk8(q & mk, e);
    endtask
    // stretch output, looked at two settled cycles later
    task automatic ck(input logic e);
        repeat (2) @(negedge clk_i);
        chk1(d_scl_oe, e);
    endtask
    task automatic wait_ack();
        int n;
        for (n = 0; n < 300 && m_ack !== 1'b1; n++) @(posedge clk_i);
        if (n >= 300) begin
            fail("no ack phase");
            test_done();
        end
    endtask
    task automatic put(input logic [7:0] b, input logic ea);
        logic [7:0] r;
        logic k;
        m.xfer(b, 1'b1, r, k);
        chk1(k, ea);
    endtask
    task automatic get(input logic ma, input logic [7:0] e);
        logic [7:0] r;
        logic k;
        m.xfer(8'hff, ma, r, k);
        chk8(r, e);
    endtask

    // --------
    // scenarios
    // --------
    task automatic t_regs();
        ck(1'b0);
        rc(`I2CS_OFS_STAT, 8'hff, 8'h00);
        rc(`I2CS_OFS_CTL, 8'hff, 8'h10);
        rc(`I2CS_OFS_CTL2, 8'hff, 8'h00);
        rc(`I2CS_OFS_IRQ, 8'hff, 8'h00);
        rc(8'h18, 8'hff, 8'h00);
        wr(`I2CS_OFS_CTL2, 8'h04);
        rc(`I2CS_OFS_CTL2, 8'hff, 8'h84);
        wr(`I2CS_OFS_CTL2, 8'h01);
        rc(`I2CS_OFS_CTL2, 8'hff, 8'h81);
        wr(`I2CS_OFS_OWN, 8'h54);
        wr(`I2CS_OFS_CTL, 8'h30);
        $display("test regs done");
    endtask
    task automatic t_rx();
        m.start();
        put(8'h54, 1'b0);
        ck(1'b0);
        rc(`I2CS_OFS_STAT, 8'h07, 8'h01);
        rc(`I2CS_OFS_IRQ, 8'h08, 8'h08);
        wr(`I2CS_OFS_IRQ, 8'h00);
        rc(`I2CS_OFS_DATA, 8'hff, 8'h54);
        rc(`I2CS_OFS_STAT, 8'h01, 8'h00);
        put(8'ha5, 1'b0);
        ck(1'b1);
        rc(`I2CS_OFS_CTL, 8'h10, 8'h00);
        rc(`I2CS_OFS_STAT, 8'h01, 8'h01);
        wr(`I2CS_OFS_CTL, 8'h30);
        ck(1'b0);
        put(8'h3c, 1'b1);
        rc(`I2CS_OFS_CTL, 8'h40, 8'h40);
        rc(`I2CS_OFS_DATA, 8'hff, 8'ha5);
        wr(`I2CS_OFS_CTL, 8'h30);
        wr(`I2CS_OFS_IRQ, 8'h00);
        m.stop();
        $display("test receive done");
    endtask
    task automatic t_early();
        m.start();
        put(8'h54, 1'b0);
        rc(`I2CS_OFS_DATA, 8'hff, 8'h54);
        fork
            put(8'h11, 1'b0);
            begin
                wait_ack();
                rc(`I2CS_OFS_DATA, 8'hff, 8'h11);
            end
        join
        ck(1'b0);
        rc(`I2CS_OFS_CTL, 8'h10, 8'h10);
        m.stop();
        $display("test early read done");
    endtask
    task automatic t_tx();
        m.start();
        put(8'h55, 1'b0);
        ck(1'b1);
        rc(`I2CS_OFS_STAT, 8'h07, 8'h04);
        rc(`I2CS_OFS_DATA, 8'hff, 8'h55);
        rc(`I2CS_OFS_CTL, 8'h10, 8'h00);
        wr(`I2CS_OFS_IRQ, 8'h00);
        wr(`I2CS_OFS_DATA, 8'h96);
        rc(`I2CS_OFS_STAT, 8'h01, 8'h01);
        wr(`I2CS_OFS_CTL, 8'h30);
        get(1'b0, 8'h96);
        rc(`I2CS_OFS_IRQ, 8'h08, 8'h08);
        rc(`I2CS_OFS_STAT, 8'h01, 8'h00);
        ck(1'b1);
        wr(`I2CS_OFS_IRQ, 8'h00);
        wr(`I2CS_OFS_DATA, 8'h3c);
        wr(`I2CS_OFS_CTL, 8'h30);
        fork
            get(1'b0, 8'h3c);
            begin
                wait_ack();
                wr(`I2CS_OFS_DATA, 8'he1);
            end
        join
        ck(1'b0);
        rc(`I2CS_OFS_CTL, 8'h10, 8'h10);
        get(1'b1, 8'he1);
        rc(`I2CS_OFS_STAT, 8'h07, 8'h00);
        ck(1'b0);
        m.stop();
        wr(`I2CS_OFS_IRQ, 8'h00);
        $display("test transmit done");
    endtask
    task automatic t_ten();
        wr(`I2CS_OFS_OWN, 8'h06);
        wr(`I2CS_OFS_CTL, 8'h38);
        m.start();
        put(8'hf6, 1'b0);
        ck(1'b1);
        rc(`I2CS_OFS_STAT, 8'h03, 8'h03);
        rc(`I2CS_OFS_CTL, 8'h10, 8'h10);
        rc(`I2CS_OFS_DATA, 8'hff, 8'hf6);
        wr(`I2CS_OFS_OWN, 8'h7b);
        rc(`I2CS_OFS_STAT, 8'h02, 8'h00);
        ck(1'b0);
        put(8'h7b, 1'b0);
        ck(1'b1);
        rc(`I2CS_OFS_STAT, 8'h03, 8'h03);
        rc(`I2CS_OFS_CTL, 8'h10, 8'h10);
        rc(`I2CS_OFS_DATA, 8'hff, 8'h7b);
        wr(`I2CS_OFS_OWN, 8'h06);
        ck(1'b0);
        put(8'h42, 1'b0);
        ck(1'b1);
        rc(`I2CS_OFS_CTL, 8'h10, 8'h00);
        rc(`I2CS_OFS_DATA, 8'hff, 8'h42);
        wr(`I2CS_OFS_CTL, 8'h38);
        m.start();
        put(8'hf7, 1'b0);
        ck(1'b1);
        rc(`I2CS_OFS_STAT, 8'h07, 8'h04);
        wr(`I2CS_OFS_CTL, 8'h38);
        m.stop();
        $display("test ten-bit done");
    endtask

    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        t_regs();
        t_rx();
        t_early();
        t_tx();
        t_ten();
        test_done();
    end
    always @(posedge m_hang) begin
        fail("clock held");
        test_done();
    end
endmodule
`default_nettype wire
